// file: sfr_param_rom.sv
/*
 * sfr_param_rom: serial read port of the discoverable-parameter table
 * slice 219h..23Dh, mode 0 framing (sample on rise, shift on fall).
 * Assumes the serial clock runs at most core_clk/8 so that the three-stage
 * input filter sees every level; bytes outside the slice read as FFh.
 */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1 - byte 219h reads 03h, deep power-down entry time of 3 us.
// R2 - byte 21Ah reads 0Ah, deep power-down exit time of 10 us.
// R3 - reserved bytes 21Bh to 21Fh read FFh.
// R4 - the list gives program 02h, quad program 32h and resume 30h.
// R5 - the list gives block protection read 72h, write 42h, lock-down 8Dh.
// R6 - byte 231h reads E8h, the nonvolatile lock-down opcode.
// R7 - byte 232h reads 98h, the global unlock opcode.
// R8 - the list gives security id read 88h, program A5h and lockout 85h.
// R9 - byte 23Bh reads ABh, the release from deep power-down opcode.
// R10 - bits 4:0 of byte 23Ch hold 00110b, six wait clocks.
// R11 - bits 7:5 of byte 23Ch hold 000b, no mode bits.
// R12 - byte 23Dh reads ECh, the 1-4-4 wrap read opcode.
// R13 - time entries hold the plain hex form of their count in the unit.
// R14 - reads use opcode, 24-bit address, a dummy byte, then auto-increment.
// R15 - contents are fixed and no write or mode change alters them.
module sfr_param_rom
    import sfr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe
);

    // pin synchronisers, three stages each
    logic [2:0] sclk_s_ff;
    logic [2:0] cs_s_ff;
    logic [2:0] si_s_ff;
    logic [2:0] nxt_sclk_s;
    logic [2:0] nxt_cs_s;
    logic [2:0] nxt_si_s;
    logic sclk_f_ff;
    logic cs_n_f_ff;
    logic nxt_sclk_f;
    logic nxt_cs_n_f;
    logic sclk_rise;
    logic sclk_fall;
    logic sclk_agree;
    logic cs_agree;

    always_comb begin
        nxt_sclk_s = {sclk_s_ff[1:0], sclk_i};
        nxt_cs_s = {cs_s_ff[1:0], cs_n_i};
        nxt_si_s = {si_s_ff[1:0], si_i};
        sclk_agree = (sclk_s_ff[1] == sclk_s_ff[2]);
        cs_agree = (cs_s_ff[1] == cs_s_ff[2]);
        nxt_sclk_f = sclk_agree ? sclk_s_ff[2] : sclk_f_ff;
        nxt_cs_n_f = cs_agree ? cs_s_ff[2] : cs_n_f_ff;
        sclk_rise = sclk_agree && sclk_s_ff[2] && !sclk_f_ff;
        sclk_fall = sclk_agree && !sclk_s_ff[2] && sclk_f_ff;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclk_s_ff <= 3'h0;
            cs_s_ff <= 3'h7;
            si_s_ff <= 3'h0;
            sclk_f_ff <= 1'b0;
            cs_n_f_ff <= 1'b1;
        end else begin
            sclk_s_ff <= nxt_sclk_s;
            cs_s_ff <= nxt_cs_s;
            si_s_ff <= nxt_si_s;
            sclk_f_ff <= nxt_sclk_f;
            cs_n_f_ff <= nxt_cs_n_f;
        end
    end

    // frame state
    sfr_state_t state_ff;
    sfr_state_t nxt_state;
    logic [2:0] bit_cnt_ff;
    logic [2:0] nxt_bit_cnt;
    logic [4:0] byte_cnt_ff;
    logic [4:0] nxt_byte_cnt;
    logic [7:0] rx_ff;
    logic [7:0] nxt_rx;
    logic [23:0] addr_ff;
    logic [23:0] nxt_addr;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic so_ff;
    logic nxt_so;
    logic so_oe_ff;
    logic nxt_so_oe;
    logic [7:0] rx_byte;
    logic [7:0] cur_byte;

    // table lookup
    // R1 entry time byte
    // R2 exit time byte
    // R3 reserved bytes fill
    // R4 program opcodes listed
    // R5 protection opcodes listed
    // R6 nonvolatile lock opcode
    // R7 global unlock opcode
    // R8 security id opcodes
    // R9 power-down release opcode
    // R10 wrap wait clocks
    // R11 wrap mode bits
    // R12 wrap read opcode
    // R13 times as counts
    logic [SFR_DEPTH-1:0] hit;
    genvar gi;
    generate
        for (gi = 0; gi < SFR_DEPTH; gi++) begin : g_entry
            // one comparator per entry keeps the decode flat and free of a subtractor
            assign hit[gi] = (addr_ff == SFR_BASE_ADDR + 24'(gi));
        end
    endgenerate

    // R15 fixed contents
    always_comb begin
        // anything outside the slice reads as the reserved fill
        cur_byte = SFR_FILL;
        for (int i = 0; i < SFR_DEPTH; i++) begin
            if (hit[i]) begin
                cur_byte = SFR_ROM[i];
            end
        end
    end

    // receive shifter and bit counter
    always_comb begin
        nxt_rx = rx_ff;
        nxt_bit_cnt = bit_cnt_ff;
        rx_byte = {rx_ff[6:0], si_s_ff[2]};
        if (cs_n_f_ff) begin
            // every frame starts on a byte boundary
            nxt_bit_cnt = 3'h0;
        end else if (sclk_rise) begin
            nxt_rx = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_cnt_ff <= 3'h0;
            rx_ff <= 8'h00;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            rx_ff <= nxt_rx;
        end
    end

    // frame control
    always_comb begin
        nxt_state = state_ff;
        nxt_byte_cnt = byte_cnt_ff;
        nxt_addr = addr_ff;

        if (cs_n_f_ff) begin
            // deselect ends any frame; a partial byte is simply dropped
            nxt_state = ST_CMD;
            nxt_byte_cnt = 5'h00;
        end else begin
            unique case (state_ff)
                ST_CMD: begin
                    // R14 opcode decode
                    if (sclk_rise && bit_cnt_ff == SFR_BIT_LAST) begin
                        nxt_byte_cnt = 5'h00;
                        if (rx_byte == SFR_CMD_READ_PARAM) begin
                            nxt_state = ST_ADDR;
                        end else begin
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    // R14 address msb first
                    if (sclk_rise) begin
                        nxt_addr = {addr_ff[22:0], si_s_ff[2]};
                        if (bit_cnt_ff == SFR_BIT_LAST) begin
                            nxt_byte_cnt = byte_cnt_ff + 5'h01;
                            if (byte_cnt_ff == SFR_ADDR_BYTES - 5'h01) begin
                                nxt_byte_cnt = 5'h00;
                                nxt_state = ST_DUMMY;
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    // R14 dummy byte
                    if (sclk_rise && bit_cnt_ff == SFR_BIT_LAST) begin
                        nxt_byte_cnt = byte_cnt_ff + 5'h01;
                        if (byte_cnt_ff == SFR_DUMMY_BYTES - 5'h01) begin
                            nxt_state = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // R14 address steps on each byte load, wrapping at 24 bits
                    if (sclk_fall && bit_cnt_ff == 3'h0) begin
                        nxt_addr = addr_ff + 24'h000001;
                    end
                end
                ST_IGNORE: begin
                    // unsupported opcodes: the rest of the frame is not decoded
                    nxt_state = ST_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_CMD;
            byte_cnt_ff <= 5'h00;
            addr_ff <= 24'h000000;
        end else begin
            state_ff <= nxt_state;
            byte_cnt_ff <= nxt_byte_cnt;
            addr_ff <= nxt_addr;
        end
    end

    // output stage
    always_comb begin
        nxt_tx = tx_ff;
        nxt_so = so_ff;
        nxt_so_oe = so_oe_ff;
        if (cs_n_f_ff) begin
            // deselect releases the pin at once, even in mid-byte
            nxt_so = 1'b0;
            nxt_so_oe = 1'b0;
        end else if (state_ff == ST_DATA && sclk_fall) begin
            // R14 drive on the fall so the host samples a settled bit on the rise
            nxt_so_oe = 1'b1;
            if (bit_cnt_ff == 3'h0) begin
                nxt_so = cur_byte[7];
                nxt_tx = {cur_byte[6:0], 1'b0};
            end else begin
                nxt_so = tx_ff[7];
                nxt_tx = {tx_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_ff <= 8'h00;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else begin
            tx_ff <= nxt_tx;
            so_ff <= nxt_so;
            so_oe_ff <= nxt_so_oe;
        end
    end

    assign so_o = so_ff;
    assign so_oe = so_oe_ff;

endmodule
`default_nettype wire

// file: sfr_pkg.sv
/*
 * sfr_pkg: constants for the discoverable-parameter table slice
 * (byte addresses 219h..23Dh) and its serial read port.
 * Assumes a single 100 MHz core clock and a serial clock far slower
 * than the core clock.
 */
`default_nettype none
package sfr_pkg;
    // serial protocol
    localparam logic [7:0] SFR_CMD_READ_PARAM = 8'h5A;
    localparam int SFR_ADDR_BITS = 24;
    localparam logic [2:0] SFR_BIT_LAST = 3'h7;
    localparam logic [4:0] SFR_ADDR_BYTES = 5'h03;
    localparam logic [4:0] SFR_DUMMY_BYTES = 5'h01;

    // slice bounds
    localparam logic [23:0] SFR_BASE_ADDR = 24'h000219;
    localparam logic [23:0] SFR_LAST_ADDR = 24'h00023D;
    localparam int SFR_DEPTH = 37;
    localparam logic [7:0] SFR_FILL = 8'hFF;

    // times, stored as the plain count in their unit
    localparam int SFR_T_DPD_ENTER_US = 3;
    localparam int SFR_T_DPD_EXIT_US = 10;
    localparam logic [7:0] SFR_DPD_ENTER = 8'(SFR_T_DPD_ENTER_US);
    localparam logic [7:0] SFR_DPD_EXIT = 8'(SFR_T_DPD_EXIT_US);

    // advertised opcodes
    localparam logic [7:0] SFR_OP_PROG = 8'h02;
    localparam logic [7:0] SFR_OP_QPROG = 8'h32;
    localparam logic [7:0] SFR_OP_RESUME = 8'h30;
    localparam logic [7:0] SFR_OP_BP_RD = 8'h72;
    localparam logic [7:0] SFR_OP_BP_WR = 8'h42;
    localparam logic [7:0] SFR_OP_BP_LOCK = 8'h8D;
    localparam logic [7:0] SFR_OP_NV_LOCK = 8'hE8;
    localparam logic [7:0] SFR_OP_UNLOCK = 8'h98;
    localparam logic [7:0] SFR_OP_SID_RD = 8'h88;
    localparam logic [7:0] SFR_OP_SID_PROG = 8'hA5;
    localparam logic [7:0] SFR_OP_SID_LOCK = 8'h85;
    localparam logic [7:0] SFR_OP_DPD_EXIT = 8'hAB;
    localparam logic [7:0] SFR_OP_WRAP144 = 8'hEC;

    // 1-4-4 wrap read descriptor: mode bits in [7:5], wait clocks in [4:0]
    localparam logic [2:0] SFR_WRAP_MODE_BITS = 3'h0;
    localparam logic [4:0] SFR_WRAP_WAIT = 5'h06;
    localparam logic [7:0] SFR_WRAP_DESC = {SFR_WRAP_MODE_BITS, SFR_WRAP_WAIT};

    localparam logic [7:0] SFR_ROM [0:SFR_DEPTH-1] = '{
        SFR_DPD_ENTER, SFR_DPD_EXIT,
        SFR_FILL, SFR_FILL, SFR_FILL, SFR_FILL, SFR_FILL,
        8'h00, 8'h66, 8'h99, 8'h38, 8'hFF, 8'h05, 8'h01, 8'h35,
        8'h06, 8'h04, SFR_OP_PROG, SFR_OP_QPROG, 8'hB0, SFR_OP_RESUME,
        SFR_OP_BP_RD, SFR_OP_BP_WR, SFR_OP_BP_LOCK, SFR_OP_NV_LOCK,
        SFR_OP_UNLOCK, SFR_OP_SID_RD, SFR_OP_SID_PROG, SFR_OP_SID_LOCK,
        8'hC0, 8'h9F, 8'hAF, 8'h5A, 8'hB9, SFR_OP_DPD_EXIT,
        SFR_WRAP_DESC, SFR_OP_WRAP144
    };

    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfr_state_t;
endpackage
`default_nettype wire

// file: sfr_param_rom_sva.sv
/* pin checker for sfr_param_rom; bound to every instance of it */
`timescale 1ns/1ns
`default_nettype none
module sfr_param_rom_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic so_o,
    input wire logic so_oe
);
    logic sclk_ff, nxt_sclk;
    logic [5:0] rise_ff, nxt_rise;
    // raw pin rises in the frame, saturating one past the header
    always_comb begin
        nxt_sclk = sclk_i;
        nxt_rise = rise_ff;
        if (rst || cs_n_i) begin
            nxt_rise = 6'h00;
        end else if (sclk_i && !sclk_ff && rise_ff < 6'h29) begin
            nxt_rise = rise_ff + 6'h01;
        end
    end
    always_ff @(posedge core_clk) begin
        sclk_ff <= nxt_sclk;
        rise_ff <= nxt_rise;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    oe_start_a: assert property ($rose(so_oe) |-> rise_ff == 6'h28 && !$past(sclk_i, 4))
        else $error("so_oe rose off the first data fall");
    oe_hold_a: assert property (so_oe && !cs_n_i |=> so_oe)
        else $error("so_oe dropped while selected");
    oe_drop_a: assert property ($fell(so_oe) |-> $past(cs_n_i, 2))
        else $error("so_oe fell without deselect");
    idle_off_a: assert property (cs_n_i [*6] |-> !so_oe)
        else $error("so_oe high while deselected");
    rst_quiet_a: assert property ($fell(rst) |-> !so_oe && !so_o)
        else $error("pins not quiet after reset");
    so_edge_a: assert property ($changed(so_o) && !cs_n_i |-> !$past(sclk_i, 4) && !sclk_i)
        else $error("so_o moved away from a clock fall");
    so_stable_a: assert property ($changed(so_o) |=> $stable(so_o) [*3])
        else $error("so_o glitched");
    oe_gate_a: assert property (so_oe && !cs_n_i |-> rise_ff >= 6'h28)
        else $error("so_oe high inside the header");
    cover property ($rose(so_oe));
    cover property ($fell(so_oe));
    cover property (rise_ff == 6'h29 && !so_oe);
endmodule
bind sfr_param_rom sfr_param_rom_sva u_sva (.core_clk(core_clk), .rst(rst), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .so_o(so_o), .so_oe(so_oe));
`default_nettype wire

// file: sfr_host_model.sv
/* host controller model: clocks read frames into the table port
   from the falling core_clk edge; serial clock half period 8 cycles */
`timescale 1ns/1ns
`default_nettype none
module sfr_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    input wire logic so_o,
    input wire logic so_oe,
    output logic sclk_i,
    output logic cs_n_i,
    output logic si_i
);
    logic [7:0] rd_q[$];
    logic oe_seen;
    initial begin
        sclk_i = 0;
        cs_n_i = 1;
        si_i = 0;
    end
    task automatic half();
        repeat (8) @(negedge core_clk);
    endtask
    // opcode, 24-bit address, dummy byte, then bytes
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
        logic [39:0] hdr;
        logic [7:0] b;
        hdr = {op, a, 8'h00};
        cs_n_i = 0;
        for (int i = 39; i >= 0; i--) begin
            si_i = hdr[i];
            half();
            sclk_i = 1;
            half();
            sclk_i = 0;
        end
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                // si carries nothing now, so keep it moving
                si_i = ~si_i;
                half();
                b[i] = so_o;
                oe_seen = oe_seen | so_oe;
                sclk_i = 1;
                half();
                sclk_i = 0;
            end
            rd_q.push_back(b);
        end
        half();
        cs_n_i = 1;
        half();
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
/* tb_top: reads the table slice through the host model and
   compares every byte of each read-command frame with a table kept here */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sfr_pkg::*;
    logic core_clk, rst, sclk_i, cs_n_i, si_i, so_o, so_oe;
    logic [23:0] a;
    int fails, n_checks, seed;
    logic [295:0] tbl = 296'h030AFFFFFFFFFF00669938FF05013506040232B03072428DE89888A585C09FAF5AB9AB06EC;
    sfr_param_rom dut (.core_clk(core_clk), .rst(rst), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .si_i(si_i), .so_o(so_o), .so_oe(so_oe));
    sfr_host_model h (.core_clk(core_clk), .so_o(so_o), .so_oe(so_oe), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .si_i(si_i));
    function automatic logic [7:0] exp_b(input logic [23:0] x);
        int off;
        off = int'(x) - 32'h219;
        if (off < 0 || off > 36) return 8'hFF;
        return tbl[295 - 8 * off -: 8];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] x, input int n);
        h.oe_seen = 0;
        h.frame(op, x, n);
        for (int k = 0; k < n; k++) begin
            if (op === SFR_CMD_READ_PARAM) begin
                chk(h.rd_q.pop_front(), exp_b(x + 24'(k)));
            end else begin
                void'(h.rd_q.pop_front());
            end
        end
        chk({7'h00, h.oe_seen}, {7'h00, op === SFR_CMD_READ_PARAM});
    endtask
    task automatic pulse_rst();
        rst = 1;
        repeat (3) @(negedge core_clk);
        rst = 0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic final_report();
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        final_report();
    end
    initial begin
        seed = 32'h9a2919cb;
        pulse_rst();
        rd(SFR_CMD_READ_PARAM, 24'h000218, 40);
        for (int i = 0; i < 16; i++) begin
            a = 24'h000215 + 24'($unsigned($random(seed)) % 48);
            // odd opcodes can never be the read command
            rd(i % 4 == 3 ? 8'($random(seed)) | 8'h01 : SFR_CMD_READ_PARAM,
                i == 14 ? 24'hFFFFFE : a, 1 + i % 3);
        end
        pulse_rst();
        rd(SFR_CMD_READ_PARAM, 24'h000219, 37);
        final_report();
    end
endmodule
`default_nettype wire
